// ===== hw/nco_core.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - 20-bit accumulator readable and writable as low, high and upper bytes.
// - each selected input clock rising edge adds buffered increment to accumulator.
// - carry of the addition is the raw overflow event.
// - two-bit field selects among three input clock sources.
// - source codes: 00 hf oscillator, 01 system oscillator, 10 logic cell, 11 reserved.
// - low-byte increment write loads buffer on second input clock edge.
// - while disabled, increment buffer loads right after any increment write.
// - increment registers double-buffered; working buffer hidden from software.
// - fixed-duty mode toggles output on every overflow.
// - output-mode bit clear selects fixed duty, set selects pulse mode.
// - pulse mode: active from next input edge for selected periods.
// - three-bit pulse-width field sets active duration.
// - width field n gives 2 to the n input clock periods.
// - pulse width longer than overflow interval keeps output from toggling.
// - polarity bit inverts output as final stage.
// - polarity change with interrupts enabled raises the interrupt flag.
// - output level readable in read-only status bit and driven out.
// - overflow sets flag; request needs all four enables set.
// - reset clears every register to zero.
// - enabled with hf oscillator selected keeps that oscillator running in sleep.
module nco_core
   import nco_pkg::*;
(
   // system
   input wire logic sys_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // oscillator clock sources, sampled as levels
   input wire logic hfOscClk,
   input wire logic sysOscClk,
   input wire logic logicCell1Out,
   // results
   output logic oscOut,
   output logic irqReq,
   output logic hfOscKeepOn
);

   // registers
   logic [7:0] ctrl_q;
   logic [7:0] clkCfg_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] inc_q;
   logic [ACC_W-1:0] incBuf_q;
   logic [3:0] irqCfg_q;
   logic flag_q;
   logic [2:0] srcSync_q;
   logic [1:0] incPend_q;
   logic loadNow_q;
   logic rawOut_q;
   logic outLvl_q;
   nco_pulse_e pstate_q;
   logic [PCNT_W-1:0] pcnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irqReq_q;
   logic keepOn_q;

   // pulse width minus one for field value n
   function automatic logic [PCNT_W-1:0] widthM1(input logic [PWS_W-1:0] n);
      widthM1 = (PCNT_W'(1) << n) - PCNT_W'(1);
   endfunction

   // address decode shared by read and write paths
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_CTRL) || (a == ADDR_CLKCFG) || (a == ADDR_ACCL) || (a == ADDR_ACCH)
         || (a == ADDR_ACCU) || (a == ADDR_INCL) || (a == ADDR_INCH) || (a == ADDR_INCU)
         || (a == ADDR_IRQ);
   endfunction

   logic enable;
   logic pulseMode;
   logic polarity;
   logic [1:0] cks;
   logic [PWS_W-1:0] pws;
   logic srcSel;
   logic oscTick;
   logic [ACC_W:0] sum;
   logic carry;
   logic acc;
   logic wrEn;
   logic [7:0] wb;
   logic polChange;
   logic flagClr;

   assign enable = ctrl_q[CTRL_EN_BIT];
   assign pulseMode = ctrl_q[CTRL_PFM_BIT];
   assign polarity = ctrl_q[CTRL_POL_BIT];
   assign cks = clkCfg_q[CLK_CKS_LSB +: 2];
   assign pws = clkCfg_q[CLK_PWS_LSB +: PWS_W];
   assign acc = psel && penable && !pready_q;  // access phase, before the answer
   assign wrEn = acc && pwrite;
   assign wb = pwdata[7:0];

   // source mux; reserved code gives a still clock
   always_comb begin
      case (cks)
         CKS_HFOSC: srcSel = hfOscClk;
         CKS_SYSOSC: srcSel = sysOscClk;
         CKS_LCELL1: srcSel = logicCell1Out;
         default: srcSel = 1'b0;
      endcase
   end

   // two-flop synchroniser plus edge history; stage 0 feeds stage 1 only
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         srcSync_q <= 3'h0;
      end else begin
         srcSync_q <= {srcSync_q[1:0], srcSel};
      end
   end

   // one tick per source rising edge; the source must run below a quarter of sys_clk
   assign oscTick = srcSync_q[1] && !srcSync_q[2] && enable;
   assign sum = {1'b0, acc_q} + {1'b0, incBuf_q};
   assign carry = oscTick && sum[ACC_W];

   // apb write to control and clock config
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= RESET_BYTE;
         clkCfg_q <= RESET_BYTE;
      end else if (wrEn) begin
         if (paddr == ADDR_CTRL) begin
            ctrl_q[CTRL_EN_BIT] <= wb[CTRL_EN_BIT];
            ctrl_q[CTRL_POL_BIT] <= wb[CTRL_POL_BIT];
            ctrl_q[CTRL_PFM_BIT] <= wb[CTRL_PFM_BIT];
         end
         if (paddr == ADDR_CLKCFG) begin
            clkCfg_q[CLK_PWS_LSB +: PWS_W] <= wb[CLK_PWS_LSB +: PWS_W];
            clkCfg_q[CLK_CKS_LSB +: 2] <= wb[CLK_CKS_LSB +: 2];
         end
      end
   end

   // accumulator: bus bytes win over the adder; running writes are undefined by contract
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= '0;
      end else if (wrEn && paddr == ADDR_ACCL) begin
         acc_q[7:0] <= wb;
      end else if (wrEn && paddr == ADDR_ACCH) begin
         acc_q[15:8] <= wb;
      end else if (wrEn && paddr == ADDR_ACCU) begin
         acc_q[ACC_W-1:16] <= wb[UPPER_W-1:0];
      end else if (oscTick) begin
         acc_q <= sum[ACC_W-1:0];
      end
   end

   // software-visible increment bytes
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         inc_q <= '0;
      end else if (wrEn) begin
         if (paddr == ADDR_INCL) inc_q[7:0] <= wb;
         if (paddr == ADDR_INCH) inc_q[15:8] <= wb;
         if (paddr == ADDR_INCU) inc_q[ACC_W-1:16] <= wb[UPPER_W-1:0];
      end
   end

   // load requests for the working buffer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         incPend_q <= 2'h0;
         loadNow_q <= 1'b0;
      end else begin
         loadNow_q <= wrEn && !enable
            && (paddr == ADDR_INCL || paddr == ADDR_INCH || paddr == ADDR_INCU);
         if (wrEn && enable && paddr == ADDR_INCL) begin
            incPend_q <= INC_LOAD_EDGES;
         end else if (oscTick && incPend_q != 2'h0) begin
            incPend_q <= incPend_q - 2'h1;
         end
      end
   end

   // hidden working buffer, all bytes at once
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         incBuf_q <= '0;
      end else if (loadNow_q || (oscTick && incPend_q == 2'h1)) begin
         incBuf_q <= inc_q;
      end
   end

   // pulse stretcher; a new overflow while active extends the pulse
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pstate_q <= PS_IDLE;
         pcnt_q <= '0;
      end else if (!enable || !pulseMode) begin
         pstate_q <= PS_IDLE;
         pcnt_q <= '0;
      end else if (oscTick) begin
         case (pstate_q)
            PS_IDLE: begin
               if (carry) pstate_q <= PS_ARMED;
            end
            PS_ARMED: begin
               pstate_q <= PS_ACTIVE;
               pcnt_q <= widthM1(pws);
            end
            PS_ACTIVE: begin
               if (carry) begin
                  pcnt_q <= widthM1(pws) + PCNT_W'(1);
               end else if (pcnt_q == '0) begin
                  pstate_q <= PS_IDLE;
               end else begin
                  pcnt_q <= pcnt_q - PCNT_W'(1);
               end
            end
            default: pstate_q <= PS_IDLE;
         endcase
      end
   end

   // fixed duty toggle flop; pulse mode follows the stretcher
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rawOut_q <= 1'b0;
      end else if (pulseMode) begin
         rawOut_q <= (pstate_q == PS_ACTIVE);
      end else if (carry) begin
         rawOut_q <= !rawOut_q;
      end
   end

   // polarity as the last stage
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         outLvl_q <= 1'b0;
      end else begin
         outLvl_q <= rawOut_q ^ polarity;
      end
   end

   // interrupt flag; hardware set wins over a software clear in the same cycle
   assign polChange = wrEn && paddr == ADDR_CTRL && wb[CTRL_POL_BIT] != polarity
      && irqCfg_q[IRQ_IE_BIT - 1];
   assign flagClr = wrEn && paddr == ADDR_IRQ && !wb[IRQ_FLAG_BIT];
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (carry || polChange) begin
         flag_q <= 1'b1;
      end else if (flagClr) begin
         flag_q <= 1'b0;
      end
   end

   // irq enable bits: ie, pe, ge in bits 0..2
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqCfg_q <= 4'h0;
      end else if (wrEn && paddr == ADDR_IRQ) begin
         irqCfg_q <= {1'b0, wb[IRQ_GE_BIT], wb[IRQ_PE_BIT], wb[IRQ_IE_BIT]};
      end
   end

   // request and sleep keep-alive outputs
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqReq_q <= 1'b0;
         keepOn_q <= 1'b0;
      end else begin
         irqReq_q <= flag_q && enable && (&irqCfg_q[2:0]);
         keepOn_q <= enable && cks == CKS_HFOSC;
      end
   end

   // apb answer: one wait state, then pready with data or error
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped(paddr);
         prdata_q <= '0;
         if (acc && !pwrite) begin
            case (paddr)
               ADDR_CTRL: begin
                  prdata_q[CTRL_EN_BIT] <= enable;
                  prdata_q[CTRL_OUT_BIT] <= outLvl_q;
                  prdata_q[CTRL_POL_BIT] <= polarity;
                  prdata_q[CTRL_PFM_BIT] <= pulseMode;
               end
               ADDR_CLKCFG: prdata_q[7:0] <= clkCfg_q;
               ADDR_ACCL: prdata_q[7:0] <= acc_q[7:0];
               ADDR_ACCH: prdata_q[7:0] <= acc_q[15:8];
               ADDR_ACCU: prdata_q[UPPER_W-1:0] <= acc_q[ACC_W-1:16];
               ADDR_INCL: prdata_q[7:0] <= inc_q[7:0];
               ADDR_INCH: prdata_q[7:0] <= inc_q[15:8];
               ADDR_INCU: prdata_q[UPPER_W-1:0] <= inc_q[ACC_W-1:16];
               ADDR_IRQ: prdata_q[3:0] <= {irqCfg_q[2:0], flag_q};
               default: prdata_q <= '0;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign oscOut = outLvl_q;
   assign irqReq = irqReq_q;
   assign hfOscKeepOn = keepOn_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   acc_wrap_a: assert property (oscTick && !wrEn |=> acc_q == $past(sum[ACC_W-1:0]))
      else $error("accumulator did not take the sum");
   flag_set_a: assert property (carry |=> flag_q)
      else $error("overflow did not set flag");
   flag_hold_a: assert property (flag_q && !flagClr |=> flag_q)
      else $error("flag cleared without software");
   fdc_toggle_a: assert property (carry && !pulseMode |=> rawOut_q != $past(rawOut_q))
      else $error("fixed duty output did not toggle");
   pol_stage_a: assert property (##1 outLvl_q == ($past(rawOut_q) ^ $past(polarity)))
      else $error("polarity stage wrong");
   inc_off_load_a: assert property (wrEn && !enable && paddr == ADDR_INCL ##1 !wrEn |=> incBuf_q == inc_q)
      else $error("disabled increment write not loaded");
   pulse_arm_a: assert property (pulseMode && enable && pstate_q == PS_IDLE && carry
      |=> pstate_q == PS_ARMED)
      else $error("overflow did not arm pulse");
   irq_gate_a: assert property (irqReq |-> $past(flag_q) && $past(enable))
      else $error("request without flag and enable");
   keep_on_a: assert property (enable && cks == CKS_HFOSC |=> hfOscKeepOn)
      else $error("hf oscillator keep-alive missing");
   pend_load_a: assert property (oscTick && incPend_q == 2'h1 && !loadNow_q |=> incBuf_q == $past(inc_q))
      else $error("buffered increment not loaded");

endmodule // nco_core
`default_nettype wire

// ===== shared/nco_pkg.sv
// shared constants of the phase accumulator frequency generator
package nco_pkg;
   // apb byte addresses, one register per aligned word
   localparam logic [7:0] ADDR_CTRL = 8'h00;  // osc_control_reg
   localparam logic [7:0] ADDR_CLKCFG = 8'h04;  // osc_clock_config_reg
   localparam logic [7:0] ADDR_ACCL = 8'h08;
   localparam logic [7:0] ADDR_ACCH = 8'h0C;
   localparam logic [7:0] ADDR_ACCU = 8'h10;
   localparam logic [7:0] ADDR_INCL = 8'h14;
   localparam logic [7:0] ADDR_INCH = 8'h18;
   localparam logic [7:0] ADDR_INCU = 8'h1C;
   localparam logic [7:0] ADDR_IRQ = 8'h20;
   // control register fields
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_POL_BIT = 4;
   localparam int CTRL_PFM_BIT = 0;
   // clock config fields
   localparam int CLK_PWS_LSB = 5;
   localparam int CLK_CKS_LSB = 0;
   // irq register fields
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_IE_BIT = 1;
   localparam int IRQ_PE_BIT = 2;
   localparam int IRQ_GE_BIT = 3;
   // clock source encodings
   localparam logic [1:0] CKS_HFOSC = 2'h0;
   localparam logic [1:0] CKS_SYSOSC = 2'h1;
   localparam logic [1:0] CKS_LCELL1 = 2'h2;
   // accumulator and increment geometry
   localparam int ACC_W = 20;
   localparam int UPPER_W = 4;
   localparam int PWS_W = 3;
   localparam int PCNT_W = 8;
   // increment buffer loads on this many osc edges after a low-byte write
   localparam logic [1:0] INC_LOAD_EDGES = 2'h2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // pulse state machine, gray along idle-armed-active
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_ARMED = 2'b01,
      PS_ACTIVE = 2'b11
   } nco_pulse_e;
endpackage

// ===== tb/nco_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side clock sources: each gives a burst of rising edges, then rests low
module nco_src_model (
   // system
   input wire logic sys_clk,
   // burst request
   input wire logic start,
   input wire logic [8:0] nEdges,
   // source clocks
   output logic hfOscClk,
   output logic sysOscClk,
   output logic logicCell1Out,
   output logic busy
);
   // distinct half periods keep the three sources out of step
   localparam int HALF [3] = '{3, 4, 5};
   logic [2:0] clk_q = 3'h0;
   logic [8:0] left_q [3] = '{9'h0, 9'h0, 9'h0};
   int ph_q [3] = '{0, 0, 0};
   assign {logicCell1Out, sysOscClk, hfOscClk} = clk_q;
   assign busy = |{left_q[0], left_q[1], left_q[2]};
   // a period ends on the falling edge, so a burst always leaves the clock low
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (start) begin
            left_q[i] <= nEdges;
            ph_q[i] <= 0;
         end else if (left_q[i] != 9'h0) begin
            if (ph_q[i] == HALF[i] - 1) begin
               ph_q[i] <= 0;
               clk_q[i] <= ~clk_q[i];
               if (clk_q[i]) left_q[i] <= left_q[i] - 9'h1;
            end else begin
               ph_q[i] <= ph_q[i] + 1;
            end
         end
      end
   end
endmodule // nco_src_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import nco_pkg::*;
   typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} nco_row_s;
   logic sys_clk = 1'h0;
   logic arst_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, hfOscClk, sysOscClk, logicCell1Out, oscOut, irqReq, hfOscKeepOn, busy, prevOut;
   logic start = 1'h0;
   logic [8:0] nEdges = 9'h0;
   logic [19:0] a0, a1;
   int error_cnt = 0, checked = 0, rises = 0, highs = 0, r0, h0;
   // register rows: optional write, then read back
   nco_row_s rows [13] = '{
      '{1'h0, ADDR_CTRL, 8'h00, 8'h00, 1'h0}, '{1'h0, ADDR_CLKCFG, 8'h00, 8'h00, 1'h0},
      '{1'h0, ADDR_ACCU, 8'h00, 8'h00, 1'h0}, '{1'h0, ADDR_INCL, 8'h00, 8'h00, 1'h0},
      '{1'h0, ADDR_IRQ, 8'h00, 8'h00, 1'h0}, '{1'h1, ADDR_INCU, 8'hFF, 8'h0F, 1'h0},
      '{1'h1, ADDR_INCH, 8'hA5, 8'hA5, 1'h0}, '{1'h1, ADDR_ACCU, 8'hFF, 8'h0F, 1'h0},
      '{1'h1, ADDR_CLKCFG, 8'hFF, 8'hE3, 1'h0}, '{1'h1, ADDR_CTRL, 8'h10, 8'h30, 1'h0},
      '{1'h1, ADDR_CTRL, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h24, 8'h55, 8'h00, 1'h1},
      '{1'h1, ADDR_IRQ, 8'h0F, 8'h0E, 1'h0}};
   logic [1:0] cSel [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
   int cK [4] = '{2, 4, 3, 1};
   logic [7:0] cAcc [4] = '{8'h00, 8'h00, 8'h0C, 8'h00};
   logic [7:0] cCtl [4] = '{8'h80, 8'h80, 8'h80, 8'hA0};
   int pW [3] = '{0, 1, 3}, pK [3] = '{7, 7, 16}, pH [3] = '{6, 12, 0};

   always #10 sys_clk = ~sys_clk;

   nco_core nco_core_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hfOscClk(hfOscClk), .sysOscClk(sysOscClk), .logicCell1Out(logicCell1Out),
      .oscOut(oscOut), .irqReq(irqReq), .hfOscKeepOn(hfOscKeepOn));
   nco_src_model nco_src_model_inst (.sys_clk(sys_clk), .start(start), .nEdges(nEdges),
      .hfOscClk(hfOscClk), .sysOscClk(sysOscClk), .logicCell1Out(logicCell1Out), .busy(busy));

   // output monitor: rising edges and active cycles
   always @(posedge sys_clk) begin
      prevOut <= oscOut;
      if (oscOut === 1'h1 && prevOut === 1'h0) rises++;
      if (oscOut === 1'h1) highs++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // apb master: request held until pready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      // no wait-state count assumed; a hung slave is caught by the watchdog
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      bus(1'h1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      bus(1'h0, a, 32'h0, r, e);
      chk(r, {24'h0, x});
   endtask
   task automatic rdAcc(output logic [19:0] v);
      logic [31:0] r;
      logic e;
      bus(1'h0, ADDR_ACCL, 32'h0, r, e);
      v[7:0] = r[7:0];
      bus(1'h0, ADDR_ACCH, 32'h0, r, e);
      v[15:8] = r[7:0];
      bus(1'h0, ADDR_ACCU, 32'h0, r, e);
      v[19:16] = r[3:0];
   endtask
   // source bursts only happen with the bus idle, so the accumulator is never read mid-count
   task automatic burst(input int k);
      @(posedge sys_clk);
      nEdges <= 9'(k);
      start <= 1'h1;
      @(posedge sys_clk);
      start <= 1'h0;
      // busy rises only after the model has seen start
      repeat (2) @(posedge sys_clk);
      while (busy !== 1'h0) @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic rst(input int n);
      @(posedge sys_clk);
      arst_n <= 1'h0;
      repeat (n) @(posedge sys_clk);
      arst_n <= 1'h1;
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] r;
      logic e;
      rst(20);
      foreach (rows[i]) begin
         if (rows[i].w) bus(1'h1, rows[i].a, {24'h0, rows[i].d}, r, e);
         bus(1'h0, rows[i].a, 32'h0, r, e);
         chk(r, {24'h0, rows[i].x});
         chk({31'h0, e}, {31'h0, rows[i].e});
      end
      // fixed duty: increment 2^18 loaded at once while disabled, upper bytes first;
      // the rows left the accumulator upper nibble set, so it is cleared before counting
      wr(ADDR_ACCU, 8'h00);
      wr(ADDR_INCU, 8'h04);
      wr(ADDR_INCH, 8'h00);
      wr(ADDR_INCL, 8'h00);
      wr(ADDR_IRQ, 8'h0E);
      wr(ADDR_CLKCFG, 8'h00);
      wr(ADDR_CTRL, 8'h80);
      burst(6);
      rd(ADDR_ACCU, 8'h08);
      rd(ADDR_CTRL, 8'hA0);
      rd(ADDR_IRQ, 8'h0F);
      chk({31'h0, irqReq}, 32'h1);
      chk({31'h0, hfOscKeepOn}, 32'h1);
      // one enable missing holds the request off; writing a one leaves the flag set
      wr(ADDR_IRQ, 8'h0B);
      @(posedge sys_clk);
      chk({31'h0, irqReq}, 32'h0);
      rd(ADDR_IRQ, 8'h0B);
      // the request register lags the flag by one cycle, so wait past it
      wr(ADDR_IRQ, 8'h0E);
      @(posedge sys_clk);
      chk({31'h0, irqReq}, 32'h0);
      rd(ADDR_IRQ, 8'h0E);
      foreach (cSel[i]) begin
         wr(ADDR_CLKCFG, {6'h0, cSel[i]});
         burst(cK[i]);
         rd(ADDR_ACCU, cAcc[i]);
         rd(ADDR_CTRL, cCtl[i]);
         chk({31'h0, hfOscKeepOn}, {31'h0, cSel[i] == 2'h0});
      end
      wr(ADDR_IRQ, 8'h0E);
      wr(ADDR_CTRL, 8'h90);
      rd(ADDR_CTRL, 8'h90);
      rd(ADDR_IRQ, 8'h0F);
      // running increment change: upper byte alone must not reach the adder
      wr(ADDR_INCU, 8'h00);
      wr(ADDR_INCH, 8'h00);
      wr(ADDR_INCL, 8'h01);
      burst(2);
      rdAcc(a0);
      wr(ADDR_INCU, 8'h01);
      rd(ADDR_INCU, 8'h01);
      burst(3);
      rdAcc(a1);
      chk({12'h0, a1}, {12'h0, a0 + 20'h3});
      rst(3);
      rd(ADDR_CTRL, 8'h00);
      rd(ADDR_INCU, 8'h00);
      chk({29'h0, oscOut, irqReq, hfOscKeepOn}, 32'h0);
      wr(ADDR_INCU, 8'h04);
      // pulse mode: overflow on the fourth edge, width from the select field
      foreach (pW[i]) begin
         wr(ADDR_CTRL, 8'h00);
         wr(ADDR_ACCU, 8'h00);
         wr(ADDR_ACCH, 8'h00);
         wr(ADDR_ACCL, 8'h00);
         wr(ADDR_CLKCFG, 8'(pW[i] << CLK_PWS_LSB));
         wr(ADDR_CTRL, 8'h81);
         r0 = rises;
         h0 = highs;
         burst(pK[i]);
         chk(32'(rises - r0), 32'h1);
         if (pH[i] != 0) chk(32'(highs - h0), 32'(pH[i]));
      end
      tally_and_finish;
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
